// file: logic/pot_cmd_defs.svh
// constants for the dual wiper command decoder
`ifndef POT_CMD_DEFS_SVH
`define POT_CMD_DEFS_SVH

// instruction byte layout
`define INSTR_OP_HI       7
`define INSTR_OP_LO       4
`define INSTR_SEL_HI      3
`define INSTR_SEL_LO      2
`define INSTR_ZERO_BIT    1
`define INSTR_POT_BIT     0

// address byte layout
`define ADDR_TYPE_HI      7
`define ADDR_TYPE_LO      4
`define ADDR_PINS_HI      3
`define ADDR_PINS_LO      0

// opcodes
`define OP_RD_WIPER       4'h9
`define OP_WR_WIPER       4'ha
`define OP_RD_STORE       4'hb
`define OP_WR_STORE       4'hc
`define OP_STORE_TO_WIPER 4'hd
`define OP_WIPER_TO_STORE 4'he
`define OP_GANG_LOAD      4'h1
`define OP_GANG_SAVE      4'h8
`define OP_STEP           4'h2

// tap range
`define TAP_MIN           6'h00
`define TAP_MAX           6'h3f
`define NV_RESET_VALUE    6'h00

// byte framing: rises counted per byte incl. acknowledge
`define BIT_LAST_DATA     4'h7
`define BIT_ACK           4'h8
`define BIT_DONE          4'h9

// timing
`define CORE_CLK_MHZ      250
`define WRITE_CYCLE_MS    5
`define WRITE_CYCLE_CYC   (`WRITE_CYCLE_MS * 1000 * `CORE_CLK_MHZ)
`define WIPER_DELAY_NS    100

`endif

// file: logic/pot_cmd_pkg.sv
// types for the dual wiper command decoder
package pot_cmd_pkg;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'b0000001,
      ST_ADDR    = 7'b0000010,
      ST_INSTR   = 7'b0000100,
      ST_DATA_RX = 7'b0001000,
      ST_DATA_TX = 7'b0010000,
      ST_STEP    = 7'b0100000,
      ST_WAIT    = 7'b1000000
   } link_state_e;

   typedef struct packed {
      logic [3:0] opcode;
      logic       setting_select_hi;
      logic       setting_select_lo;
      logic       zero_bit;
      logic       pot_select;
   } instr_s;

   typedef logic [5:0] tap_t;

endpackage : pot_cmd_pkg

// file: logic/dual_wiper_command_decoder.sv
// two-wire command decoder for a dual 64-tap wiper with stored settings
`timescale 1ns/1ps
`include "pot_cmd_defs.svh"

module dual_wiper_command_decoder
   import pot_cmd_pkg::*;
#(
   // device type field value is arbitrary
   parameter logic [3:0] DEV_TYPE        = 4'ha,
   parameter int         WRITE_CYCLE_CYC = `WRITE_CYCLE_CYC,
   parameter int         WIPER_DELAY_NS  = `WIPER_DELAY_NS,
   parameter int         TAPS            = 64,
   parameter int         SETTINGS        = 4
) (
   // core clock and reset
   input  wire logic            i_core_clk,
   input  wire logic            i_rst_n,
   // two-wire link
   input  wire logic            i_scl_clk,
   input  wire logic            i_sda_in,
   output logic                 o_sda_out,
   output logic                 o_sda_oe,
   // straps and protection
   input  wire logic [3:0]      i_board_address_pins,
   input  wire logic            i_write_protect_n,
   // tap selects and status
   output logic [TAPS-1:0]      o_tap_sel0,
   output logic [TAPS-1:0]      o_tap_sel1,
   output logic                 o_nv_busy
);

   localparam int WIPER_DELAY_CYC =
      (WIPER_DELAY_NS * `CORE_CLK_MHZ + 999) / 1000 < 1 ? 1 :
      (WIPER_DELAY_NS * `CORE_CLK_MHZ + 999) / 1000;
   localparam int BUSY_W  = $clog2(WRITE_CYCLE_CYC + 1);
   localparam int DELAY_W = $clog2(WIPER_DELAY_CYC + 1);

   function automatic logic [TAPS-1:0] tap_decode(input tap_t pos);
      tap_decode = '0;
      tap_decode[pos] = 1'b1;
   endfunction : tap_decode

   function automatic tap_t step_tap(input tap_t pos, input logic up);
      if (up)
         step_tap = (pos == `TAP_MAX) ? pos : tap_t'(pos + 6'h01);
      else
         step_tap = (pos == `TAP_MIN) ? pos : tap_t'(pos - 6'h01);
   endfunction : step_tap

   function automatic logic is_known_op(input logic [3:0] op);
      case (op)
         `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_STORE, `OP_WR_STORE,
         `OP_STORE_TO_WIPER, `OP_WIPER_TO_STORE, `OP_GANG_LOAD,
         `OP_GANG_SAVE, `OP_STEP:
            is_known_op = 1'b1;
         default:
            is_known_op = 1'b0;
      endcase
   endfunction : is_known_op

   // link-clock domain: bits shift in on each link clock rise
   logic [7:0] rx_shift_reg;

   always_ff @(posedge i_scl_clk) begin
      rx_shift_reg <= {rx_shift_reg[6:0], i_sda_in};
   end

   // pin synchronisers
   logic       scl_meta_reg;
   logic       scl_sync_reg;
   logic       sda_meta_reg;
   logic       sda_sync_reg;
   logic       wp_meta_reg;
   logic       wp_sync_reg;
   logic [3:0] pins_meta_reg;
   logic [3:0] pins_sync_reg;
   logic       scl_prev_reg;
   logic       sda_prev_reg;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         scl_meta_reg  <= 1'b1;
         scl_sync_reg  <= 1'b1;
         sda_meta_reg  <= 1'b1;
         sda_sync_reg  <= 1'b1;
         wp_meta_reg   <= 1'b0;
         wp_sync_reg   <= 1'b0;
         pins_meta_reg <= 4'h0;
         pins_sync_reg <= 4'h0;
         scl_prev_reg  <= 1'b1;
         sda_prev_reg  <= 1'b1;
      end else begin
         scl_meta_reg  <= i_scl_clk;
         scl_sync_reg  <= scl_meta_reg;
         sda_meta_reg  <= i_sda_in;
         sda_sync_reg  <= sda_meta_reg;
         wp_meta_reg   <= i_write_protect_n;
         wp_sync_reg   <= wp_meta_reg;
         pins_meta_reg <= i_board_address_pins;
         pins_sync_reg <= pins_meta_reg;
         scl_prev_reg  <= scl_sync_reg;
         sda_prev_reg  <= sda_sync_reg;
      end
   end

   logic start_evt;
   logic stop_evt;
   logic scl_rise;
   logic scl_fall;

   assign start_evt = scl_sync_reg & scl_prev_reg & sda_prev_reg &
                      ~sda_sync_reg;
   assign stop_evt  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg &
                      sda_sync_reg;
   assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall  = ~scl_sync_reg & scl_prev_reg;

   // state
   link_state_e state_reg;
   link_state_e after_reg;
   link_state_e after_next;
   logic [3:0]  bit_cnt_reg;
   logic        ack_reg;
   logic        ack_next;
   logic        oe_reg;
   logic        sda_out_reg;
   logic [7:0]  tx_reg;
   logic [7:0]  tx_next;
   instr_s      instr_reg;
   instr_s      instr_now;
   tap_t        wiper_reg   [2];
   // power-on image of the stored settings; no reset ever touches it
   tap_t        nv_mem      [2][SETTINGS] = '{default: `NV_RESET_VALUE};
   logic [BUSY_W-1:0] busy_cnt_reg;
   logic        busy;
   logic        byte_done;
   logic [7:0]  rx_byte;
   logic [1:0]  sel_now;
   logic [1:0]  sel_reg;

   // rx_shift_reg holds still for the whole link clock high phase, which
   // is far longer than the two-stage sync delay of scl, so it is read
   // only on a synchronised rise and cannot be caught mid-update
   assign rx_byte   = rx_shift_reg;
   assign instr_now = instr_s'(rx_byte);
   assign sel_now   = {instr_now.setting_select_hi,
                       instr_now.setting_select_lo};
   assign sel_reg   = {instr_reg.setting_select_hi,
                       instr_reg.setting_select_lo};
   assign busy      = (busy_cnt_reg != '0);
   assign byte_done = scl_rise && bit_cnt_reg == `BIT_LAST_DATA &&
                      (state_reg == ST_ADDR || state_reg == ST_INSTR ||
                       state_reg == ST_DATA_RX);

   // per-byte decision: acknowledge, next phase, byte to return
   always_comb begin
      ack_next   = 1'b0;
      after_next = ST_WAIT;
      tx_next    = 8'h00;
      case (state_reg)
         ST_ADDR: begin
            if (rx_byte[`ADDR_TYPE_HI:`ADDR_TYPE_LO] == DEV_TYPE &&
                rx_byte[`ADDR_PINS_HI:`ADDR_PINS_LO] == pins_sync_reg &&
                !busy) begin
               ack_next   = 1'b1;
               after_next = ST_INSTR;
            end
         end
         ST_INSTR: begin
            ack_next = is_known_op(instr_now.opcode);
            case (instr_now.opcode)
               `OP_RD_WIPER: begin
                  after_next = ST_DATA_TX;
                  tx_next    = {2'b00, wiper_reg[instr_now.pot_select]};
               end
               `OP_RD_STORE: begin
                  after_next = ST_DATA_TX;
                  tx_next    =
                     {2'b00, nv_mem[instr_now.pot_select][sel_now]};
               end
               `OP_WR_WIPER, `OP_WR_STORE: after_next = ST_DATA_RX;
               `OP_STEP:                   after_next = ST_STEP;
               default:                    after_next = ST_WAIT;
            endcase
         end
         ST_DATA_RX: begin
            // stored-setting data is refused while protected
            ack_next = !(instr_reg.opcode == `OP_WR_STORE &&
                         !wp_sync_reg);
         end
         default: ack_next = 1'b0;
      endcase
   end

   // protocol sequencer
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_reg   <= ST_IDLE;
         after_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         ack_reg     <= 1'b0;
         oe_reg      <= 1'b0;
         tx_reg      <= 8'h00;
         instr_reg   <= '0;
      end else if (stop_evt) begin
         state_reg <= ST_IDLE;
         oe_reg    <= 1'b0;
      end else if (start_evt) begin
         state_reg   <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
         oe_reg      <= 1'b0;
      end else if (state_reg == ST_ADDR || state_reg == ST_INSTR ||
                   state_reg == ST_DATA_RX ||
                   state_reg == ST_DATA_TX) begin
         if (scl_rise) begin
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            if (byte_done) begin
               ack_reg   <= ack_next;
               after_reg <= after_next;
               if (state_reg == ST_INSTR) begin
                  instr_reg <= instr_now;
                  tx_reg    <= tx_next;
               end
            end
         end else if (scl_fall) begin
            if (bit_cnt_reg == `BIT_DONE) begin
               bit_cnt_reg <= 4'h0;
               // one return byte only, so the line is free for the stop
               state_reg   <= (state_reg == ST_DATA_TX) ? ST_WAIT :
                              after_reg;
               // first return bit goes out right after the acknowledge
               oe_reg      <= (state_reg != ST_DATA_TX) &&
                              (after_reg == ST_DATA_TX) && ~tx_reg[7];
            end else if (bit_cnt_reg == `BIT_ACK) begin
               oe_reg <= (state_reg != ST_DATA_TX) & ack_reg;
            end else if (state_reg == ST_DATA_TX) begin
               oe_reg <= ~tx_reg[6];
               tx_reg <= {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

   // line only ever pulled low
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n)
         sda_out_reg <= 1'b0;
      else
         sda_out_reg <= 1'b0;
   end

   // wiper registers
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 2; p++)
            wiper_reg[p] <= nv_mem[p][0];
      end else if (byte_done && state_reg == ST_INSTR && ack_next) begin
         if (instr_now.opcode == `OP_STORE_TO_WIPER)
            wiper_reg[instr_now.pot_select] <=
               nv_mem[instr_now.pot_select][sel_now];
         else if (instr_now.opcode == `OP_GANG_LOAD)
            for (int p = 0; p < 2; p++)
               wiper_reg[p] <= nv_mem[p][sel_now];
      end else if (byte_done && state_reg == ST_DATA_RX &&
                   instr_reg.opcode == `OP_WR_WIPER) begin
         wiper_reg[instr_reg.pot_select] <= rx_byte[5:0];
      end else if (scl_rise && state_reg == ST_STEP) begin
         wiper_reg[instr_reg.pot_select] <=
            step_tap(wiper_reg[instr_reg.pot_select],
                     sda_sync_reg);
      end
   end

   // pending program, held until the stop condition; a start drops it
   logic       pend_valid_reg;
   logic [1:0] pend_mask_reg;
   logic [1:0] pend_sel_reg;
   tap_t       pend_data_reg [2];

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         pend_valid_reg <= 1'b0;
         pend_mask_reg  <= 2'b00;
         pend_sel_reg   <= 2'b00;
         for (int p = 0; p < 2; p++)
            pend_data_reg[p] <= `NV_RESET_VALUE;
      end else if (stop_evt || start_evt) begin
         pend_valid_reg <= 1'b0;
      end else if (byte_done && state_reg == ST_INSTR && ack_next &&
                   (instr_now.opcode == `OP_WIPER_TO_STORE ||
                    instr_now.opcode == `OP_GANG_SAVE)) begin
         pend_valid_reg <= 1'b1;
         pend_sel_reg   <= sel_now;
         if (instr_now.opcode == `OP_GANG_SAVE)
            pend_mask_reg <= 2'b11;
         else
            pend_mask_reg <= instr_now.pot_select ? 2'b10 : 2'b01;
         for (int p = 0; p < 2; p++)
            pend_data_reg[p] <= wiper_reg[p];
      end else if (byte_done && state_reg == ST_DATA_RX &&
                   instr_reg.opcode == `OP_WR_STORE && wp_sync_reg) begin
         pend_valid_reg <= 1'b1;
         pend_sel_reg   <= sel_reg;
         pend_mask_reg  <= instr_reg.pot_select ? 2'b10 : 2'b01;
         for (int p = 0; p < 2; p++)
            pend_data_reg[p] <= rx_byte[5:0];
      end
   end

   logic program_go;

   // protect dropping after the data byte still cancels the program
   assign program_go = stop_evt && pend_valid_reg && wp_sync_reg &&
                       !busy;

   // stored settings keep their contents through reset
   always_ff @(posedge i_core_clk) begin
      if (program_go) begin
         for (int p = 0; p < 2; p++)
            if (pend_mask_reg[p])
               nv_mem[p][pend_sel_reg] <= pend_data_reg[p];
      end
   end

   // programming cycle timer
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n)
         busy_cnt_reg <= '0;
      else if (program_go)
         busy_cnt_reg <= BUSY_W'(WRITE_CYCLE_CYC);
      else if (busy)
         busy_cnt_reg <= BUSY_W'(busy_cnt_reg - 1'b1);
   end

   // tap outputs trail the wiper registers by the response delay
   logic [DELAY_W-1:0] delay_cnt_reg [2];
   logic [TAPS-1:0]    tap_reg       [2];
   logic               busy_reg;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         for (int p = 0; p < 2; p++) begin
            delay_cnt_reg[p] <= '0;
            tap_reg[p]       <= tap_decode(nv_mem[p][0]);
         end
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (tap_decode(wiper_reg[p]) == tap_reg[p]) begin
               delay_cnt_reg[p] <= '0;
            end else if (delay_cnt_reg[p] ==
                         DELAY_W'(WIPER_DELAY_CYC - 1)) begin
               delay_cnt_reg[p] <= '0;
               tap_reg[p]       <= tap_decode(wiper_reg[p]);
            end else begin
               delay_cnt_reg[p] <=
                  DELAY_W'(delay_cnt_reg[p] + 1'b1);
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n)
         busy_reg <= 1'b0;
      else
         busy_reg <= busy;
   end

   assign o_sda_oe   = oe_reg;
   assign o_sda_out  = sda_out_reg;
   assign o_tap_sel0 = tap_reg[0];
   assign o_tap_sel1 = tap_reg[1];
   assign o_nv_busy  = busy_reg;

endmodule : dual_wiper_command_decoder

// file: testbench/dual_wiper_command_decoder_asserts.sv
// port checker for the dual wiper command decoder
`timescale 1ns/1ps
module dual_wiper_command_decoder_asserts #(
   parameter int WRITE_CYCLE_CYC = 1250000,
   parameter int TAPS            = 64
) (
   // core clock and reset
   input wire logic            i_core_clk,
   input wire logic            i_rst_n,
   // two-wire link
   input wire logic            i_scl_clk,
   input wire logic            i_sda_in,
   input wire logic            o_sda_out,
   input wire logic            o_sda_oe,
   // straps and protection
   input wire logic [3:0]      i_board_address_pins,
   input wire logic            i_write_protect_n,
   // taps and status
   input wire logic [TAPS-1:0] o_tap_sel0,
   input wire logic [TAPS-1:0] o_tap_sel1,
   input wire logic            o_nv_busy
);
   logic       scl_q;
   logic       sda_q;
   logic [7:0] fall_age;
   logic [7:0] stop_age;
   logic [7:0] idle_age;
   int         busy_cnt;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   always_ff @(posedge i_core_clk) begin
      scl_q <= i_scl_clk;
      sda_q <= i_sda_in;
   end

   // ages saturate so long idle spans never wrap
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n)
         fall_age <= 8'hff;
      else if (scl_q && !i_scl_clk)
         fall_age <= 8'h00;
      else if (fall_age != 8'hff)
         fall_age <= fall_age + 8'h01;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n)
         stop_age <= 8'hff;
      else if (scl_q && i_scl_clk && !sda_q && i_sda_in)
         stop_age <= 8'h00;
      else if (stop_age != 8'hff)
         stop_age <= stop_age + 8'h01;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || scl_q != i_scl_clk || sda_q != i_sda_in)
         idle_age <= 8'h00;
      else if (idle_age != 8'hff)
         idle_age <= idle_age + 8'h01;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || !o_nv_busy)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end

   AST_TAP0_ONEHOT: assert property ($onehot(o_tap_sel0))
      else $error("pot 0 tap select not one-hot");
   AST_TAP1_ONEHOT: assert property ($onehot(o_tap_sel1))
      else $error("pot 1 tap select not one-hot");
   AST_DRIVE_AFTER_FALL: assert property (
      $changed(o_sda_oe) |-> fall_age inside {[8'h01:8'h07]})
      else $error("data drive moved away from a clock fall");
   AST_BUSY_LENGTH: assert property (
      $fell(o_nv_busy) |-> busy_cnt >= WRITE_CYCLE_CYC - 1
         && busy_cnt <= WRITE_CYCLE_CYC + 1)
      else $error("programming time wrong");
   AST_BUSY_AFTER_STOP: assert property (
      $rose(o_nv_busy) |-> stop_age < 8'h10)
      else $error("programming began without a stop");
   AST_BUSY_NO_ACK: assert property (o_nv_busy |-> !o_sda_oe)
      else $error("data line driven while programming");
   AST_BUSY_TAPS_HOLD: assert property (
      o_nv_busy [*2] |-> $stable(o_tap_sel0) && $stable(o_tap_sel1))
      else $error("taps moved while programming");
   AST_PROTECT_NO_PROGRAM: assert property (
      (!i_write_protect_n) [*8] |=> !$rose(o_nv_busy))
      else $error("programming while protected");
   AST_TAPS_IDLE_HOLD: assert property (
      idle_age > 8'h40 |-> $stable(o_tap_sel0) && $stable(o_tap_sel1))
      else $error("taps moved on an idle bus");
   AST_SDA_OUT_LOW: assert property (!o_sda_out)
      else $error("data line driven high instead of released");

   cover property ($rose(o_nv_busy));
   cover property ($rose(o_sda_oe));
   cover property (o_tap_sel0[TAPS-1]);
endmodule : dual_wiper_command_decoder_asserts

bind dual_wiper_command_decoder dual_wiper_command_decoder_asserts #(
   .WRITE_CYCLE_CYC(WRITE_CYCLE_CYC),
   .TAPS(TAPS)
) u_asserts (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl_clk(i_scl_clk),
   .i_sda_in(i_sda_in), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .i_board_address_pins(i_board_address_pins),
   .i_write_protect_n(i_write_protect_n), .o_tap_sel0(o_tap_sel0),
   .o_tap_sel1(o_tap_sel1), .o_nv_busy(o_nv_busy)
);

// file: testbench/pot_bus_master.sv
// two-wire bus master model that frames commands for the decoder
`timescale 1ns/1ps
module pot_bus_master #(
   parameter int PH = 14
) (
   // tick clock and resolved data wire
   input  wire logic i_tick_clk,
   input  wire logic i_sda,
   // bus lines; clock stands high between frames
   output logic      o_scl,
   output logic      o_sda_pull
);
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end

   task automatic half;
      repeat (PH) @(posedge i_tick_clk);
   endtask : half

   task automatic start;
      half();
      o_sda_pull <= 1'b1;
      half();
      o_scl <= 1'b0;
   endtask : start

   // data moves a little after the fall, never with it
   task automatic bitio(input logic b, output logic r);
      repeat (2) @(posedge i_tick_clk);
      o_sda_pull <= ~b;
      half();
      o_scl <= 1'b1;
      half();
      r = i_sda;
      o_scl <= 1'b0;
   endtask : bitio

   task automatic xbyte(input logic [7:0] d, output logic [7:0] q,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitio(d[i], q[i]);
      bitio(1'b1, r);
      ack = ~r;
   endtask : xbyte

   task automatic stop;
      repeat (2) @(posedge i_tick_clk);
      o_sda_pull <= 1'b1;
      half();
      o_scl <= 1'b1;
      half();
      o_sda_pull <= 1'b0;
      half();
   endtask : stop
endmodule : pot_bus_master

// file: testbench/dual_wiper_command_decoder_tb.sv
// self-checking bench for the dual wiper command decoder
`timescale 1ns/1ps
`include "pot_cmd_defs.svh"
module dual_wiper_command_decoder_tb
   import pot_cmd_pkg::*;
;
   localparam int         WCC   = 1000;
   // device type value is arbitrary
   localparam logic [3:0] DTYPE = 4'ha;
   logic        i_core_clk;
   logic        tick_clk;
   logic        i_rst_n;
   logic        wp_n;
   logic [3:0]  pins;
   logic        scl;
   logic        pull;
   logic        sda_oe;
   logic        busy;
   logic [63:0] tap0;
   logic [63:0] tap1;
   logic [7:0]  own;
   logic [7:0]  q;
   logic [2:0]  ak;
   logic [1:0]  s2;
   logic        b;
   logic        r;
   tap_t        v;
   tap_t        wip [2];
   tap_t        nv [2][4];
   int          seed;
   int          bad_count;
   int          checks;
   int          cyc;
   wire         sda = ~(pull | sda_oe);

   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   initial begin
      tick_clk = 1'b0;
      #1.3;
      forever #3 tick_clk = ~tick_clk;
   end

   dual_wiper_command_decoder #(
      .DEV_TYPE(DTYPE),
      .WRITE_CYCLE_CYC(WCC)
   ) uut (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl_clk(scl),
      .i_sda_in(sda), .o_sda_out(), .o_sda_oe(sda_oe),
      .i_board_address_pins(pins), .i_write_protect_n(wp_n),
      .o_tap_sel0(tap0), .o_tap_sel1(tap1), .o_nv_busy(busy)
   );
   pot_bus_master m (
      .i_tick_clk(tick_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull)
   );

   function automatic logic [63:0] hot(input tap_t t);
      return 64'h1 << t;
   endfunction : hot

   function automatic tap_t step(input tap_t t, input logic up);
      if (up)
         return (t == `TAP_MAX) ? t : t + 6'h01;
      return (t == `TAP_MIN) ? t : t - 6'h01;
   endfunction : step

   task automatic end_of_test;
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic chk_taps;
      cmp(tap0, hot(wip[0]));
      cmp(tap1, hot(wip[1]));
   endtask : chk_taps

   task automatic cmd(input logic [7:0] a, input logic [3:0] op,
                      input logic [1:0] s, input logic p,
                      input logic [7:0] d);
      m.start();
      m.xbyte(a, q, ak[2]);
      m.xbyte({op, s, 1'b0, p}, q, ak[1]);
      ak[0] = 1'b0;
      q = 8'h00;
      if (op inside {`OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_STORE, `OP_WR_STORE})
         m.xbyte(d, q, ak[0]);
      m.stop();
   endtask : cmd

   // bounded wait covers programming plus the tap response delay
   task automatic settle;
      repeat (40) @(posedge i_core_clk);
      for (int i = 0; i < 1200 && busy !== 1'b0; i++)
         @(posedge i_core_clk);
      repeat (40) @(posedge i_core_clk);
   endtask : settle

   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 100000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      seed = 52;
      bad_count = 0;
      checks = 0;
      cyc = 0;
      i_rst_n = 1'b0;
      wp_n = 1'b1;
      pins = 4'h0;
      foreach (nv[p, s])
         nv[p][s] = `NV_RESET_VALUE;
      @(posedge i_core_clk);
      pins <= 4'($random(seed));
      repeat (7) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      repeat (6) @(posedge i_core_clk);
      own = {DTYPE, pins};
      wip[0] = nv[0][0];
      wip[1] = nv[1][0];
      chk_taps();
      for (int i = 0; i < 2; i++) begin
         cmd(i ? {~DTYPE, pins} : {DTYPE, ~pins}, `OP_WR_WIPER, 2'b00,
             1'b0, 8'h2a);
         settle();
         cmp(ak, 3'b000);
         chk_taps();
      end
      for (int ph = 0; ph < 2; ph++)
         for (int k = 0; k < 8; k++) begin
            if (ph == 0) begin
               v = (k == 7) ? `TAP_MAX : tap_t'($random(seed));
               nv[k[2]][k[1:0]] = v;
               cmd(own, `OP_WR_STORE, k[1:0], k[2], {2'b00, v});
               cmp(ak, 3'b111);
               if (k == 0) begin
                  m.start();
                  m.xbyte(own, q, ak[2]);
                  m.stop();
                  cmp({busy, ak[2]}, 2'b10);
               end
            end else begin
               cmd(own, `OP_RD_STORE, k[1:0], k[2], 8'hff);
               cmp(q, {2'b00, nv[k[2]][k[1:0]]});
            end
            settle();
         end
      for (int p = 0; p < 2; p++) begin
         v = tap_t'($random(seed));
         cmd(own, `OP_WR_WIPER, 2'b00, p[0], {2'b00, v});
         wip[p] = v;
         cmp(ak, 3'b111);
         settle();
         chk_taps();
         cmd(own, `OP_RD_WIPER, 2'b00, p[0], 8'hff);
         cmp({ak, q}, {3'b110, 2'b00, v});
         settle();
      end
      s2 = 2'($random(seed));
      cmd(own, `OP_STORE_TO_WIPER, s2, 1'b1, 8'hff);
      wip[1] = nv[1][s2];
      cmp(ak, 3'b110);
      settle();
      chk_taps();
      cmd(own, `OP_WIPER_TO_STORE, s2 ^ 2'b01, 1'b0, 8'hff);
      nv[0][s2 ^ 2'b01] = wip[0];
      settle();
      cmd(own, `OP_RD_STORE, s2 ^ 2'b01, 1'b0, 8'hff);
      cmp(q, {2'b00, wip[0]});
      settle();
      cmd(own, `OP_GANG_SAVE, s2, 1'b0, 8'hff);
      nv[0][s2] = wip[0];
      nv[1][s2] = wip[1];
      settle();
      wp_n <= 1'b0;
      cmd(own, `OP_WR_STORE, s2, 1'b1, 8'h15);
      cmp({busy, ak}, 4'b0110);
      settle();
      cmd(own, 4'h3, 2'b00, 1'b0, 8'hff);
      cmp(ak, 3'b100);
      wp_n <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         cmd(own, `OP_WR_WIPER, 2'b00, p[0], 8'h3e);
         wip[p] = 6'h3e;
         settle();
         m.start();
         m.xbyte(own, q, ak[2]);
         m.xbyte({`OP_STEP, 3'b000, p[0]}, q, ak[1]);
         for (int i = 0; i < 80; i++) begin
            b = (i < 3) || (i >= 70 && $random(seed) % 2 != 0);
            m.bitio(b, r);
            wip[p] = step(wip[p], b);
         end
         // the stop's own clock rise counts as a down step
         m.stop();
         wip[p] = step(wip[p], 1'b0);
         settle();
         chk_taps();
      end
      cmd(own, `OP_GANG_LOAD, s2, 1'b0, 8'hff);
      wip[0] = nv[0][s2];
      wip[1] = nv[1][s2];
      settle();
      chk_taps();
      i_rst_n <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      repeat (6) @(posedge i_core_clk);
      wip[0] = nv[0][0];
      wip[1] = nv[1][0];
      chk_taps();
      end_of_test();
   end
endmodule : dual_wiper_command_decoder_tb
